// ---- inc/reset_source_map.svh ----
`ifndef RESET_SOURCE_MAP_SVH
`define RESET_SOURCE_MAP_SVH
// Overview of operation
// - power-on reset clears the program counter to zero
// - power-on reset sets all port data and direction registers to ones
// - undervoltage reset always on in run modes; resets and sets its flag
// - supply-low shorter than the filter time is ignored
// - four valid threshold codes: 0x55, 0x33, 0x99, 0xAA
// - invalid threshold code resets after soft delay; register restored to 0x55
// - invalid threshold code sets the select fault flag
// - genuine low-supply reset preserves the threshold register
// - threshold register holds 0x55 after power-on
// - undervoltage detection disabled in sleep or idle
// - undervoltage flag sticky, cleared only by software writing zero
// - select fault flag sticky, cleared only by software writing zero
// - undervoltage flag is control bit 2, unknown at power-on; reset here loads zero
// - select fault flag is control bit 1, zero at power-on
// - control bits 6 and 3 read as zero
// - watchdog time-out in run mode is a full reset plus timeout flag
// - watchdog time-out in sleep or idle clears only pc and sp, sets timeout flag
// - timeout and powerdown flags zero at power-on, kept on undervoltage reset
// - sleep or idle watchdog reset leaves both flags at one
// - watchdog control fault flag is bit 0, set by hardware, cleared by software

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define UV_SEL_ADDR        12'h000
`define SYS_CTRL_ADDR      12'h004
`define STATUS_ADDR        12'h008

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define UV_SEL_POR         8'h55
`define UV_CODE_2V10       8'h55
`define UV_CODE_2V55       8'h33
`define UV_CODE_3V15       8'h99
`define UV_CODE_3V80       8'hAA
`define CTRL_IDLE_KEEP_BIT 7
`define CTRL_FREQ_LSB      4
`define CTRL_UVF_BIT       2
`define CTRL_SELF_BIT      1
`define CTRL_WDF_BIT       0
`define CTRL_RW_MASK       8'hB0
`define STAT_TO_BIT        0
`define STAT_PDF_BIT       1
`define PORT_POR           8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define UV_FILTER_NS       120
`define SOFT_RESET_NS      200
`define RESET_PULSE_CYC    4
`endif

// ---- inc/reset_source_pkg.sv ----
package reset_source_pkg;
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_SOFTW = 4'b0010,
        ST_FULL  = 4'b0100,
        ST_WARM  = 4'b1000
    } seq_state_e;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'b00,
        CAUSE_UV   = 2'b01,
        CAUSE_SEL  = 2'b10,
        CAUSE_WDOG = 2'b11
    } cause_e;
endpackage

// ---- inc/delay_if.sv ----
`timescale 1ns/100ps
interface delay_if;
    logic        start;
    logic        run;
    logic        done;
    logic [15:0] limit;
    modport owner (output start, output run, output limit, input done);
    modport timer (input start, input run, input limit, output done);
endinterface

// ---- hw/delay_counter.sv ----
`timescale 1ns/100ps
module delay_counter (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    delay_if.timer    dif
);
    logic [15:0] cnt_r;

    // ----------------------------------------------------------------
    // counter: restarts on start, holds at zero while run is low
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || !dif.run || dif.start) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r != dif.limit) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign dif.done = dif.run && !dif.start && (cnt_r == dif.limit);
endmodule

// ---- hw/reset_source_control.sv ----
`timescale 1ns/100ps
`include "reset_source_map.svh"
module reset_source_control
    import reset_source_pkg::*;
#(
    parameter int UV_FILTER_CYC  = (`UV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int SOFT_RESET_CYC = (`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [11:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        supply_low_i,
    input  wire logic        sleep_mode_i,
    input  wire logic        wdog_timeout_i,
    input  wire logic        wdog_ctrl_fault_i,
    input  wire logic        halt_exec_i,
    input  wire logic        wdog_clear_i,
    output logic             full_reset_o,
    output logic             pc_sp_clear_o,
    output logic      [7:0]  port_data_o,
    output logic      [7:0]  port_dir_o,
    output logic             idle_sysclk_keep_o,
    output logic      [1:0]  fast_osc_freq_select_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    seq_state_e  state_r;
    logic [7:0]  uv_threshold_select_r;
    logic [7:0]  ctrl_rw_r;
    logic        uv_reset_flag_r;
    logic        uv_select_fault_flag_r;
    logic        wdog_ctrl_fault_flag_r;
    logic        wdog_timeout_flag_r;
    logic        powerdown_flag_r;
    logic [2:0]  pulse_cnt_r;
    cause_e      cause_r;
    logic        uv_valid;
    logic        uv_event;
    logic        sel_event;
    logic        run_mode;

    delay_if uv_dif ();
    delay_if sel_dif ();

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [11:0] addr_r;
    logic        ctrl_wr;
    logic        sel_wr;
    logic        stat_wr;
    logic [7:0]  wbyte;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 12'h000;
        end else if (hready_i) begin
            wr_pend_r <= hsel_i && htrans_i[1] && hwrite_i;
            rd_pend_r <= hsel_i && htrans_i[1] && !hwrite_i;
            addr_r    <= haddr_i;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign wbyte       = hwdata_i[7:0];
    assign sel_wr      = wr_pend_r && (addr_r == `UV_SEL_ADDR);
    assign ctrl_wr     = wr_pend_r && (addr_r == `SYS_CTRL_ADDR);
    assign stat_wr     = wr_pend_r && (addr_r == `STATUS_ADDR);

    // read data from a register, loaded at the address phase
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i)
                `UV_SEL_ADDR:   hrdata_o <= {24'h00_0000, uv_threshold_select_r};
                `SYS_CTRL_ADDR: hrdata_o <= {24'h00_0000, ctrl_rw_r[7], 1'b0, ctrl_rw_r[5:4], 1'b0,
                                             uv_reset_flag_r, uv_select_fault_flag_r, wdog_ctrl_fault_flag_r};
                `STATUS_ADDR:   hrdata_o <= {30'h0000_0000, powerdown_flag_r, wdog_timeout_flag_r};
                default:        hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    assign run_mode = !sleep_mode_i;
    always_comb begin
        unique case (uv_threshold_select_r)
            `UV_CODE_2V10, `UV_CODE_2V55, `UV_CODE_3V15, `UV_CODE_3V80: uv_valid = 1'b1;
            default: uv_valid = 1'b0;
        endcase
    end

    // filter: supply-low must persist through the whole count
    assign uv_dif.start = 1'b0;
    assign uv_dif.run   = supply_low_i && run_mode && (state_r == ST_RUN || state_r == ST_SOFTW);
    assign uv_dif.limit = 16'(UV_FILTER_CYC);
    assign uv_event     = uv_dif.done;

    assign sel_dif.start = 1'b0;
    // the soft delay sleeps like the undervoltage filter, so a bad code cannot reset while asleep
    assign sel_dif.run   = !uv_valid && run_mode && (state_r == ST_RUN || state_r == ST_SOFTW);
    assign sel_dif.limit = 16'(SOFT_RESET_CYC);
    assign sel_event     = sel_dif.done;

    delay_counter u_uv_filter (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .dif    (uv_dif)
    );

    delay_counter u_soft_delay (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .dif    (sel_dif)
    );

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r     <= ST_RUN;
            pulse_cnt_r <= 3'h0;
            cause_r     <= CAUSE_NONE;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    pulse_cnt_r <= 3'h0;
                    if (uv_event) begin
                        state_r <= ST_FULL;
                        cause_r <= CAUSE_UV;
                    end else if (wdog_timeout_i && run_mode) begin
                        state_r <= ST_FULL;
                        cause_r <= CAUSE_WDOG;
                    end else if (wdog_timeout_i) begin
                        state_r <= ST_WARM;
                        cause_r <= CAUSE_WDOG;
                    end else if (!uv_valid) begin
                        state_r <= ST_SOFTW;
                    end
                end
                ST_SOFTW: begin
                    // a pending soft reset must not hide a supply drop or a watchdog time-out
                    if (uv_event) begin
                        state_r <= ST_FULL;
                        cause_r <= CAUSE_UV;
                    end else if (wdog_timeout_i && run_mode) begin
                        state_r <= ST_FULL;
                        cause_r <= CAUSE_WDOG;
                    end else if (wdog_timeout_i) begin
                        state_r <= ST_WARM;
                        cause_r <= CAUSE_WDOG;
                    end else if (uv_valid) begin
                        state_r <= ST_RUN;
                    end else if (sel_event) begin
                        state_r <= ST_FULL;
                        cause_r <= CAUSE_SEL;
                    end
                end
                ST_FULL, ST_WARM: begin
                    pulse_cnt_r <= pulse_cnt_r + 3'h1;
                    if (pulse_cnt_r == 3'(`RESET_PULSE_CYC - 1)) begin
                        state_r <= ST_RUN;
                        cause_r <= CAUSE_NONE;
                    end
                end
            endcase
        end
    end

    assign full_reset_o  = rst_i || (state_r == ST_FULL);
    assign pc_sp_clear_o = full_reset_o || (state_r == ST_WARM);

    // last cycle of a reset pulse: everything else already initialised
    logic apply_cause;
    assign apply_cause = (state_r != ST_RUN) && (state_r != ST_SOFTW)
                         && (pulse_cnt_r == 3'(`RESET_PULSE_CYC - 1));

    // ----------------------------------------------------------------
    // port registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || state_r == ST_FULL) begin
            port_data_o <= `PORT_POR;
            port_dir_o  <= `PORT_POR;
        end
    end

    // ----------------------------------------------------------------
    // threshold select register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uv_threshold_select_r <= `UV_SEL_POR;
        end else if (state_r == ST_FULL && cause_r != CAUSE_UV) begin
            uv_threshold_select_r <= `UV_SEL_POR;
        end else if (sel_wr && state_r != ST_FULL) begin
            uv_threshold_select_r <= wbyte;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || state_r == ST_FULL) begin
            ctrl_rw_r <= 8'h00;
        end else if (ctrl_wr) begin
            ctrl_rw_r <= wbyte & `CTRL_RW_MASK;
        end
    end
    assign idle_sysclk_keep_o     = ctrl_rw_r[`CTRL_IDLE_KEEP_BIT];
    assign fast_osc_freq_select_o = ctrl_rw_r[`CTRL_FREQ_LSB +: 2];

    // sticky flags: set wins over a software clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uv_reset_flag_r <= 1'b0; // unknown at power-on, zero chosen
        end else if (apply_cause && cause_r == CAUSE_UV) begin
            uv_reset_flag_r <= 1'b1;
        end else if (ctrl_wr && !wbyte[`CTRL_UVF_BIT]) begin
            uv_reset_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uv_select_fault_flag_r <= 1'b0;
        end else if ((!uv_valid && state_r == ST_SOFTW) || (apply_cause && cause_r == CAUSE_SEL)) begin
            uv_select_fault_flag_r <= 1'b1;
        end else if (ctrl_wr && !wbyte[`CTRL_SELF_BIT]) begin
            uv_select_fault_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wdog_ctrl_fault_flag_r <= 1'b0;
        end else if (wdog_ctrl_fault_i) begin
            wdog_ctrl_fault_flag_r <= 1'b1;
        end else if (ctrl_wr && !wbyte[`CTRL_WDF_BIT]) begin
            wdog_ctrl_fault_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // timeout and powerdown flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wdog_timeout_flag_r <= 1'b0;
        end else if (apply_cause && cause_r == CAUSE_WDOG) begin
            wdog_timeout_flag_r <= 1'b1;
        end else if (wdog_clear_i || halt_exec_i || (stat_wr && !wbyte[`STAT_TO_BIT])) begin
            wdog_timeout_flag_r <= 1'b0;
        end
    end

    // a watchdog wake from sleep sets the powerdown flag, as halt does
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            powerdown_flag_r <= 1'b0;
        end else if (halt_exec_i || (apply_cause && state_r == ST_WARM)) begin
            powerdown_flag_r <= 1'b1;
        end else if (wdog_clear_i) begin
            powerdown_flag_r <= 1'b0;
        end
    end
endmodule

// ---- test/reset_source_control_checker.sv ----
`timescale 1ns/100ps
`include "reset_source_map.svh"
module reset_source_control_checker #(
    parameter int UV_FILTER_CYC  = 12,
    parameter int SOFT_RESET_CYC = 20
) (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        sleep_mode_i,
    input wire logic        wdog_timeout_i,
    input wire logic        full_reset_o,
    input wire logic        pc_sp_clear_o,
    input wire logic [7:0]  port_data_o,
    input wire logic [7:0]  port_dir_o
);
    // ----------------
    // reset and control readback properties
    // ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic ctrl_rd_r;
    always_ff @(posedge mclk_i) begin
        ctrl_rd_r <= !rst_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == `SYS_CTRL_ADDR;
    end
    AST_PORT_HIGH: assert property (port_data_o == 8'hFF && port_dir_o == 8'hFF)
        else $error("port registers not all ones");
    AST_PC_WITH_FULL: assert property (full_reset_o |-> pc_sp_clear_o)
        else $error("full reset without pc clear");
    AST_WDOG_RUN: assert property (wdog_timeout_i && !sleep_mode_i && !pc_sp_clear_o |=> full_reset_o[*4])
        else $error("run time-out gave no full reset");
    AST_WDOG_SLEEP: assert property (wdog_timeout_i && sleep_mode_i && !pc_sp_clear_o
        |=> (pc_sp_clear_o && !full_reset_o)[*4]) else $error("sleep time-out not a warm pulse");
    AST_SLEEP_NO_FULL: assert property (sleep_mode_i && !full_reset_o |=> !full_reset_o)
        else $error("full reset while asleep");
    AST_PULSE_LEN: assert property ($rose(full_reset_o) |-> full_reset_o[*4] ##1 !full_reset_o)
        else $error("full reset pulse length wrong");
    AST_WARM_LEN: assert property ($rose(pc_sp_clear_o) && !full_reset_o
        |-> pc_sp_clear_o[*4] ##1 !pc_sp_clear_o) else $error("warm pulse length wrong");
    AST_CTRL_GAPS: assert property (ctrl_rd_r |-> hrdata_o[6] == 1'b0 && hrdata_o[3] == 1'b0)
        else $error("control bit 6 or 3 read as one");
endmodule
bind reset_source_control reset_source_control_checker #(
    .UV_FILTER_CYC (UV_FILTER_CYC),
    .SOFT_RESET_CYC(SOFT_RESET_CYC)
) u_reset_source_control_checker (
    .mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
    .sleep_mode_i, .wdog_timeout_i, .full_reset_o, .pc_sp_clear_o, .port_data_o, .port_dir_o
);

// ---- test/reset_source_control_tb.sv ----
`timescale 1ns/100ps
`include "reset_source_map.svh"
module reset_source_control_tb;
    localparam int UVF = 4;
    localparam int SRD = 6;
    logic        mclk_i;
    logic        rst_i;
    logic        hsel_i;
    logic [11:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [31:0] hwdata_i;
    logic        supply_low_i;
    logic        sleep_mode_i;
    logic [3:0]  ev;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        full_reset_o;
    logic        pc_sp_clear_o;
    logic [7:0]  port_data_o;
    logic [7:0]  port_dir_o;
    logic        idle_sysclk_keep_o;
    logic [1:0]  fast_osc_freq_select_o;
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] codes [4] = '{32'h0000_0055, 32'h0000_0033, 32'h0000_0099, 32'h0000_00AA};
    logic        fr_q;
    logic        pc_q;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_full = 0;
    int          n_warm = 0;
    int          nf;
    int          cyc = 0;

    reset_source_control #(
        .UV_FILTER_CYC (UVF),
        .SOFT_RESET_CYC(SRD)
    ) u_reset_source_control (
        .mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'b010), .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o(), .supply_low_i, .sleep_mode_i,
        .wdog_timeout_i(ev[0]), .wdog_ctrl_fault_i(ev[1]), .halt_exec_i(ev[2]), .wdog_clear_i(ev[3]),
        .full_reset_o, .pc_sp_clear_o, .port_data_o, .port_dir_o, .idle_sysclk_keep_o,
        .fast_osc_freq_select_o
    );

    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] ctrl_exp(input logic [31:0] w, input logic [2:0] fl);
        return (w & 32'h0000_00B0) | {29'h0, fl};
    endfunction
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // master holds each phase until hready, never assumes a latency
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        check(nm, q, exp);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge mclk_i);
        ev[i] <= 1'b0;
    endtask
    task automatic low_for(input int n);
        supply_low_i <= 1'b1;
        repeat (n) @(posedge mclk_i);
        supply_low_i <= 1'b0;
    endtask
    // bounded wait until the expected pulses happened and both reset outputs drop
    task automatic wait_rst(input int ef, input int ew);
        int k;
        k = 0;
        while ((n_full != ef || n_warm != ew || full_reset_o !== 1'b0 || pc_sp_clear_o !== 1'b0) && k < 100) begin
            @(posedge mclk_i);
            k++;
        end
        check("reset outputs", {full_reset_o, pc_sp_clear_o}, 32'h0000_0000);
        check("full resets", n_full, ef);
        check("warm resets", n_warm, ew);
    endtask

    // ----------------
    // clock, monitor, sequence
    // ----------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (full_reset_o === 1'b1 && fr_q !== 1'b1) n_full++;
        if (pc_sp_clear_o === 1'b1 && pc_q !== 1'b1 && full_reset_o !== 1'b1) n_warm++;
        fr_q <= full_reset_o;
        pc_q <= pc_sp_clear_o;
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        {rst_i, hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i} = {1'b1, 48'h0};
        {supply_low_i, sleep_mode_i, ev} = 6'h00;
        r = $urandom(10245);
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`UV_SEL_ADDR, "threshold", 32'h0000_0055);
        rd(`SYS_CTRL_ADDR, "control", 32'h0000_0000);
        rd(`STATUS_ADDR, "status", 32'h0000_0000);
        nf = n_full;
        foreach (codes[i]) begin
            bus(`UV_SEL_ADDR, 1'b1, codes[i]);
            rd(`UV_SEL_ADDR, "threshold", codes[i]);
        end
        // flag bits written as one must stay clear
        repeat (6) begin
            r = $urandom;
            bus(`SYS_CTRL_ADDR, 1'b1, r);
            rd(`SYS_CTRL_ADDR, "control", ctrl_exp(r, 3'b000));
            check("ctrl pins", {idle_sysclk_keep_o, fast_osc_freq_select_o}, {r[7], r[5:4]});
        end
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0000);
        low_for(UVF);
        repeat (8) @(posedge mclk_i);
        check("short low", n_full, nf);
        low_for(UVF + 3);
        nf++;
        wait_rst(nf, 0);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b100));
        rd(`UV_SEL_ADDR, "threshold", 32'h0000_00AA);
        rd(`STATUS_ADDR, "status", 32'h0000_0000);
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0004);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b100));
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0000);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b000));
        sleep_mode_i <= 1'b1;
        low_for(UVF + 6);
        sleep_mode_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check("sleep low", n_full, nf);
        r = {24'h0, 8'($urandom)};
        while (r inside {codes}) r = {24'h0, 8'($urandom)};
        bus(`UV_SEL_ADDR, 1'b1, r);
        // the state machine needs one edge to see the bad code and one more to raise the flag
        repeat (2) @(posedge mclk_i);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b010));
        nf++;
        wait_rst(nf, 0);
        rd(`UV_SEL_ADDR, "threshold", 32'h0000_0055);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b010));
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0000);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b000));
        pulse(1);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b001));
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0000);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(0, 3'b000));
        pulse(0);
        nf++;
        wait_rst(nf, 0);
        rd(`STATUS_ADDR, "status", 32'h0000_0001);
        pulse(2);
        bus(`SYS_CTRL_ADDR, 1'b1, 32'h0000_0030);
        sleep_mode_i <= 1'b1;
        pulse(0);
        wait_rst(nf, 1);
        sleep_mode_i <= 1'b0;
        rd(`STATUS_ADDR, "status", 32'h0000_0003);
        rd(`SYS_CTRL_ADDR, "control", ctrl_exp(32'h0000_0030, 3'b000));
        pulse(3);
        rd(`STATUS_ADDR, "status", 32'h0000_0000);
        pulse(2);
        bus(`UV_SEL_ADDR, 1'b1, 32'h0000_0099);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`UV_SEL_ADDR, "threshold", 32'h0000_0055);
        rd(`SYS_CTRL_ADDR, "control", 32'h0000_0000);
        rd(`STATUS_ADDR, "status", 32'h0000_0000);
        finish_test();
    end
endmodule
